// ==== verilog/fqtr_pkg.sv ====
// constants for the flash query table rom: byte addresses, contents, apb map
package fqtr_pkg;
    // query byte addresses
    localparam logic [8:0] QA_GEOM_FIRST = 9'h027;
    localparam logic [8:0] QA_GEOM_LAST = 9'h038;
    localparam logic [8:0] QA_EXT_FIRST = 9'h10a;
    localparam logic [8:0] QA_EXT_LAST = 9'h117;
    localparam logic [8:0] QA_SIGNATURE = 9'h10a;
    localparam logic [8:0] QA_MAJOR = 9'h10d;
    localparam logic [8:0] QA_MINOR = 9'h10e;
    localparam logic [8:0] QA_FEATURE = 9'h10f;
    localparam logic [8:0] QA_AFTER_SUSPEND = 9'h113;
    localparam logic [8:0] QA_BLOCK_MASK = 9'h114;
    localparam logic [8:0] QA_CORE_VOLT = 9'h116;
    localparam logic [8:0] QA_PROG_VOLT = 9'h117;
    // extended query contents
    localparam logic [23:0] SIGNATURE_VAL = 24'h495250;
    localparam logic [7:0] MAJOR_VAL = 8'h31;
    localparam logic [7:0] MINOR_VAL = 8'h35;
    localparam logic [31:0] FEATURE_VAL = 32'h000001e6;
    localparam logic [7:0] AFTER_SUSPEND_VAL = 8'h01;
    localparam logic [15:0] BLOCK_MASK_VAL = 16'h0003;
    localparam logic [7:0] CORE_VOLT_VAL = 8'h30;
    localparam logic [7:0] PROG_VOLT_VAL = 8'h90;
    // geometry: common head 27..2c, then two region entries 2d..34
    localparam logic [7:0] DEV_SIZE_EXP = 8'h19;
    localparam logic [15:0] IFACE_CODE = 16'h0001;
    localparam logic [15:0] BUF_EXP = 16'h000a;
    localparam logic [7:0] REGION_COUNT = 8'h02;
    localparam logic [31:0] REGION_PARAM = 32'h00800003;
    localparam logic [31:0] REGION_MAIN = 32'h020000fe;
    // apb map: query byte a sits at byte address 4*a
    localparam logic [11:0] APB_QUERY_BASE = 12'h000;
    localparam logic [11:0] APB_CTRL = 12'h800;
    localparam int CTRL_QMODE_BIT = 0;
    localparam int CTRL_TOP_BIT = 1;
    localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
endpackage

// ==== verilog/fqtr_rom.sv ====
// apb-readable flash query table: geometry map and primary extended query
// What this block does
// - bytes 10a..10c return ascii signature 50 52 49
// - 10d returns major version 31, 10e minor version 35
// - 10f..112 form feature word, low bytes e6 01, bits 11-29 zero
// - feature word flags suspend, locking, otp, page and sync reads only
// - feature bits 30 and 31 read zero, no continuation field
// - 113 returns 01: program allowed during erase suspend
// - 114..115 block status mask reads 03 00
// - 116 core supply voltage code 30, hex volts and bcd tenths
// - 117 program supply voltage code 90, same encoding
// - 27..2c read 19 01 00 0a 00 02 for both configurations
// - region entries swap order between bottom and top; 35..38 zero
// - byte 27 is log2 of capacity in bytes
// - region entry: count minus one low half, size in 256 bytes high
// - bytes 2a..2b give log2 of write buffer bytes
module fqtr_rom #(
    parameter bit TOP_CONFIG = 1'b0
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic qmode_q;
    logic qmode_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic [7:0] qbyte;
    logic [8:0] qaddr;
    logic [31:0] region_lo;
    logic [31:0] region_hi;
    logic [4:0] geo_idx;
    logic [3:0] ext_idx;
    logic [8:0] ext_off;
    logic [111:0] ext_img;
    logic [143:0] geo_img;
    logic access;

    assign access = psel && penable;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_q;
    assign qaddr = paddr[10:2];

    // swap order of region entries with the block configuration
    assign region_lo = TOP_CONFIG ? fqtr_pkg::REGION_MAIN : fqtr_pkg::REGION_PARAM;
    assign region_hi = TOP_CONFIG ? fqtr_pkg::REGION_PARAM : fqtr_pkg::REGION_MAIN;

    // images are little endian, lowest address in the low byte
    assign geo_img = {32'h00000000, region_hi, region_lo,
                      fqtr_pkg::REGION_COUNT, fqtr_pkg::BUF_EXP,
                      fqtr_pkg::IFACE_CODE, fqtr_pkg::DEV_SIZE_EXP};
    assign ext_img = {fqtr_pkg::PROG_VOLT_VAL,
                      fqtr_pkg::CORE_VOLT_VAL,
                      fqtr_pkg::BLOCK_MASK_VAL,
                      fqtr_pkg::AFTER_SUSPEND_VAL,
                      fqtr_pkg::FEATURE_VAL,
                      fqtr_pkg::MINOR_VAL, fqtr_pkg::MAJOR_VAL,
                      fqtr_pkg::SIGNATURE_VAL};
    assign geo_idx = 5'(qaddr - fqtr_pkg::QA_GEOM_FIRST);
    assign ext_off = qaddr - fqtr_pkg::QA_EXT_FIRST;
    assign ext_idx = ext_off[3:0];

    always_comb
    begin
        qbyte = 8'h00;
        if (qaddr >= fqtr_pkg::QA_GEOM_FIRST && qaddr <= fqtr_pkg::QA_GEOM_LAST)
        begin
            qbyte = geo_img[geo_idx*8 +: 8];
        end
        else if (qaddr >= fqtr_pkg::QA_EXT_FIRST && qaddr <= fqtr_pkg::QA_EXT_LAST)
        begin
            qbyte = ext_img[ext_idx*8 +: 8];
        end
    end

    always_comb
    begin
        qmode_d = qmode_q;
        prdata_d = prdata_q;
        if (access && pwrite && paddr == fqtr_pkg::APB_CTRL)
        begin
            qmode_d = pwdata[fqtr_pkg::CTRL_QMODE_BIT];
        end
        if (psel && !penable && !pwrite)
        begin
            // data captured in setup so it is valid during the access phase
            if (paddr == fqtr_pkg::APB_CTRL)
            begin
                prdata_d = 32'h00000000;
                prdata_d[fqtr_pkg::CTRL_QMODE_BIT] = qmode_q;
                prdata_d[fqtr_pkg::CTRL_TOP_BIT] = TOP_CONFIG;
            end
            else if (paddr[11] == 1'b0 && paddr[1:0] == 2'b00 && qmode_q)
            begin
                prdata_d = {24'h000000, qbyte};
            end
            else
            begin
                prdata_d = fqtr_pkg::RD_UNMAPPED;
            end
        end
    end

    // query area has no write path at all
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            qmode_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            qmode_q <= qmode_d;
            prdata_q <= prdata_d;
        end
    end
endmodule

// ==== tb/fqtr_rom_checker.sv ====
// port-level assertions for the query table rom
module fqtr_rom_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic rd = psel && penable && !pwrite;
    // zero is allowed too: reads with query mode off return zero
    property rdv(logic [11:0] a, logic [31:0] v);
        rd && paddr == a |-> prdata inside {32'h0, v};
    endproperty
    sig_byte_a: assert property (rdv(12'h428, 32'h50)) else $error("signature");
    major_ver_a: assert property (rdv(12'h434, 32'h31)) else $error("major");
    feat_low_a: assert property (rdv(12'h43c, 32'he6)) else $error("feature");
    feat_top_a: assert property (rdv(12'h448, 32'h0)) else $error("feature top");
    susp_fn_a: assert property (rdv(12'h44c, 32'h01)) else $error("suspend");
    blk_mask_a: assert property (rdv(12'h450, 32'h03)) else $error("mask");
    core_volt_a: assert property (rdv(12'h458, 32'h30)) else $error("core volt");
    prog_volt_a: assert property (rdv(12'h45c, 32'h90)) else $error("prog volt");
    low_lane_a: assert property (rd && paddr < 12'h800 |-> prdata[31:8] == 24'h0)
        else $error("upper lanes");
endmodule
bind fqtr_rom fqtr_rom_checker u_fqtr_rom_checker (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata);

// ==== tb/fqtr_host.sv ====
// apb master standing in for the host memory controller
module fqtr_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // leading edge wait keeps back-to-back calls from double-driving psel
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic ok);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        ok = 1'b0;
        for (int i = 0; i < 16 && !ok; i++)
        begin
            @(posedge pclk);
            ok = (pready === 1'b1);
        end
        q = prdata;
        {psel, penable} <= 2'b00;
    endtask
endmodule

// ==== tb/tb_flash_query_table_rom.sv ====
// self-checking bench for the query table rom, bottom configuration plus region entries of the top configuration
module tb_flash_query_table_rom;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, ok;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    // second instance in the top configuration shares the bus, writes included; only its prdata is checked
    logic [31:0] prdata_top;
    logic [7:0] top_bytes [8] = '{8'hfe, 8'h00, 8'h00, 8'h02, 8'h03, 8'h00, 8'h80, 8'h00};
    int failures = 0;
    int samples_checked = 0;
    // query address in 16:8, expected byte in 7:0
    logic [16:0] rows [30] = '{17'h10a50, 17'h10b52, 17'h10c49, 17'h10d31, 17'h10e35,
        17'h10fe6, 17'h11001, 17'h11100, 17'h11200, 17'h11301, 17'h11403, 17'h11500,
        17'h11630, 17'h11790, 17'h02719, 17'h02801, 17'h02900, 17'h02a0a, 17'h02b00,
        17'h02c02, 17'h02d03, 17'h02e00, 17'h02f80, 17'h03000, 17'h031fe, 17'h03200,
        17'h03300, 17'h03402, 17'h03500, 17'h03800};
    always #20 pclk = ~pclk;
    fqtr_rom #(.TOP_CONFIG(1'b0)) u_fqtr_rom (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr);
    fqtr_rom #(.TOP_CONFIG(1'b1)) u_fqtr_rom_top (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata(prdata_top), .pready(), .pslverr());
    fqtr_host u_fqtr_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);
    task automatic end_of_test();
        if (failures == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, e);
        u_fqtr_host.xfer(w, a, d, q, ok);
        samples_checked++;
        if (ok !== 1'b1 || pslverr !== 1'b0 || (!w && q !== e))
        begin
            failures++;
            $display("CHECK FAILED access %h expected %h seen %h", a, e, q);
            if (ok !== 1'b1)
                end_of_test();
        end
    endtask
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        acc(0, 12'h428, 0, 32'h0);
        acc(1, 12'h800, 1, 0);
        acc(0, 12'h800, 0, 32'h1);
        foreach (rows[i])
            acc(0, {1'b0, rows[i][16:8], 2'b00}, 0, {24'h0, rows[i][7:0]});
        foreach (top_bytes[i])
        begin
            u_fqtr_host.xfer(1'b0, 12'(12'h0b4 + 4 * i), 32'h0, q, ok);
            samples_checked++;
            if (ok !== 1'b1 || prdata_top !== {24'h0, top_bytes[i]})
            begin
                failures++;
                $display("CHECK FAILED top region %0d expected %h seen %h", i, top_bytes[i],
                    prdata_top);
            end
        end
        acc(1, 12'h428, 32'hff, 0);
        acc(0, 12'h428, 0, 32'h50);
        acc(0, 12'h429, 0, 32'h0);
        acc(0, 12'h900, 0, 32'h0);
        end_of_test();
    end
endmodule
